// File: logic/fbac_pkg.sv
// Package for the bytewide nonvolatile memory host controller.
// Assumes a 50 MHz system clock; all timing counts derive from it.
package fbac_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int ROW_BYTES_LOG2 = 3;
  // Chip enable access time, worst supply range
  localparam int ACCESS_TIME_NS = 80;
  // Minimum precharge time, worst supply range
  localparam int PRECHARGE_MIN_TIME_NS = 65;
  // Setup of address before chip enable falls
  localparam int ADDR_SETUP_NS = 20;
  // Least times round up to whole cycles
  localparam int ACCESS_CYC =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC =
    (PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC =
    (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] PRECHARGE_CNT = CNT_W'(PRECHARGE_CYC);
  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_PRECHARGE
  } fbac_state_e;
endpackage

// File: logic/fbac_tmr_if.sv
// Interface between the sequencer and its phase timer.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface fbac_tmr_if;
  logic load;
  logic [fbac_pkg::CNT_W-1:0] loadVal;
  logic done;
  modport ctl (output load, output loadVal, input done);
  modport tmr (input load, input loadVal, output done);
endinterface

// File: logic/fbac_phase_timer.sv
// Down counter that times one phase of a memory cycle.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
module fbac_phase_timer (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  fbac_tmr_if.tmr tmr // Load and done
);
  logic [fbac_pkg::CNT_W-1:0] cnt_ff;
  logic [fbac_pkg::CNT_W-1:0] nxt_cnt;
  wire running = (cnt_ff != fbac_pkg::CNT_ZERO);
  assign nxt_cnt = tmr.load ? tmr.loadVal :
                   running ? cnt_ff - fbac_pkg::CNT_ONE : cnt_ff;
  // Done depends on the count only; load is decoded from it
  assign tmr.done = (cnt_ff == fbac_pkg::CNT_ONE);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= fbac_pkg::CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// File: logic/fbac_host_ctrl.sv
// Host controller driving a 32K x 8 bytewide nonvolatile memory.
// Assumes device pins are synchronous to clk; bus wire resolved outside.
//
// Behaviour
// - Host holds write and chip enable low at least the access time.
// - Host holds write data stable before the end of the write.
// - Host raises chip enable and holds it high the precharge time.
// - Host keeps chip enable low no longer than needed.
// - Every access gets its own chip enable falling edge.
// - Host keeps chip enable high through reset and power transitions; the code covers reset only, having no power-fail input.
// - Host keeps write enable high during power transitions; the code has no power-fail input, only reset forces it high.
// - One 8-bit two-way bus: host drives writes, device drives reads.
`timescale 1ns/1ps
module fbac_host_ctrl (
  input wire logic clk, // System clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic reqValid, // Request present
  output logic reqReady, // Request taken this cycle
  input wire logic reqWrite, // 1 write, 0 read
  input wire logic [fbac_pkg::ADDR_W-1:0] reqAddr, // Byte address
  input wire logic [fbac_pkg::DATA_W-1:0] reqWdata, // Write data
  output logic rspValid, // One-cycle completion pulse
  output logic [fbac_pkg::DATA_W-1:0] rspRdata, // Read data
  output logic [fbac_pkg::ADDR_W-fbac_pkg::ROW_BYTES_LOG2-1:0] rspRow, // Row
  output logic busy, // Cycle in progress
  output logic chipEnN, // Chip enable to device, low
  output logic writeEnN, // Write enable to device, low
  output logic outEnN, // Output enable to device, low
  output logic [fbac_pkg::ADDR_W-1:0] addr_lines, // Address to device
  input wire logic [fbac_pkg::DATA_W-1:0] data_lines_i, // Bus level in
  output logic [fbac_pkg::DATA_W-1:0] data_lines_o, // Bus drive value
  output logic data_lines_oe // High while host drives bus
);
  localparam int ROW_W = fbac_pkg::ADDR_W - fbac_pkg::ROW_BYTES_LOG2;

  // ------------------------------------------------------------
  // State and timer
  // ------------------------------------------------------------
  fbac_pkg::fbac_state_e state_ff;
  fbac_pkg::fbac_state_e nxt_state;
  logic write_ff;
  logic chipEnN_ff;
  logic writeEnN_ff;
  logic outEnN_ff;
  logic oe_ff;
  logic [fbac_pkg::ADDR_W-1:0] addr_ff;
  logic [fbac_pkg::DATA_W-1:0] wdata_ff;
  logic [fbac_pkg::DATA_W-1:0] rdata_ff;
  logic [ROW_W-1:0] row_ff;
  logic rspValid_ff;

  // ------------------------------------------------------------
  // Phase timer
  // ------------------------------------------------------------
  // One down counter times setup, access and precharge in turn
  fbac_tmr_if tmrBus ();

  fbac_phase_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .tmr(tmrBus.tmr)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire isIdle = (state_ff == fbac_pkg::ST_IDLE);
  wire isSetup = (state_ff == fbac_pkg::ST_SETUP);
  wire isAccess = (state_ff == fbac_pkg::ST_ACCESS);
  wire isPre = (state_ff == fbac_pkg::ST_PRECHARGE);
  wire take = isIdle && reqValid;
  wire setupDone = isSetup && tmrBus.done;
  wire accessDone = isAccess && tmrBus.done;
  wire preDone = isPre && tmrBus.done;

  // A request is taken only in idle, one cycle ahead of setup
  assign reqReady = take;
  // Reload at each phase boundary; precharge runs out to zero
  assign tmrBus.load = take || setupDone || accessDone;
  assign tmrBus.loadVal = take ? fbac_pkg::SETUP_CNT :
                          setupDone ? fbac_pkg::ACCESS_CNT :
                          fbac_pkg::PRECHARGE_CNT;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fbac_pkg::ST_IDLE: begin
        if (take) begin
          nxt_state = fbac_pkg::ST_SETUP;
        end
      end
      fbac_pkg::ST_SETUP: begin
        if (setupDone) begin
          nxt_state = fbac_pkg::ST_ACCESS;
        end
      end
      fbac_pkg::ST_ACCESS: begin
        if (accessDone) begin
          nxt_state = fbac_pkg::ST_PRECHARGE;
        end
      end
      fbac_pkg::ST_PRECHARGE: begin
        if (preDone) begin
          nxt_state = fbac_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = fbac_pkg::ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Pin strobes
  // ------------------------------------------------------------
  // Chip enable low only in access; high in reset, idle, precharge
  wire cePhase = setupDone || (isAccess && !accessDone);
  wire nxtCe = !cePhase;

  // Write enable and bus drive start at the take edge, a cycle
  // ahead of chip enable, so every write is chip-enable controlled
  wire wrStart = take && reqWrite;
  wire wrHold = (isSetup || isAccess) && write_ff && !accessDone;
  wire wrPhase = wrStart || wrHold;
  wire nxtWe = !wrPhase;

  // Output enable follows chip enable on reads only
  wire rdPhase = cePhase && !write_ff;
  wire nxtOe = !rdPhase;

  // Host drives data exactly while write enable is low
  wire nxtDrv = wrPhase;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // All strobes high so no access starts during reset
      state_ff <= fbac_pkg::ST_IDLE;
      chipEnN_ff <= 1'b1;
      writeEnN_ff <= 1'b1;
      outEnN_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      chipEnN_ff <= nxtCe;
      writeEnN_ff <= nxtWe;
      outEnN_ff <= nxtOe;
      oe_ff <= nxtDrv;
    end
  end

  // ------------------------------------------------------------
  // Request capture and read data
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_ff <= 1'b0;
      addr_ff <= fbac_pkg::ADDR_RST;
      wdata_ff <= fbac_pkg::DATA_RST;
    end else if (take) begin
      // Pins keep the captured request for the whole cycle
      write_ff <= reqWrite;
      addr_ff <= reqAddr;
      wdata_ff <= reqWdata;
    end
  end

  // ------------------------------------------------------------
  // Completion
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= fbac_pkg::DATA_RST;
      row_ff <= '0;
      rspValid_ff <= 1'b0;
    end else begin
      rspValid_ff <= accessDone;
      if (accessDone) begin
        // Sampled after the full access time with output enable low
        if (!write_ff) begin
          rdata_ff <= data_lines_i;
        end
        // Row worn by this access, for wear tracking upstream
        row_ff <= addr_ff[fbac_pkg::ADDR_W-1:fbac_pkg::ROW_BYTES_LOG2];
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Device pins
  assign chipEnN = chipEnN_ff;
  assign writeEnN = writeEnN_ff;
  assign outEnN = outEnN_ff;
  assign addr_lines = addr_ff;
  assign data_lines_o = wdata_ff;
  assign data_lines_oe = oe_ff;

  // Host side
  assign rspValid = rspValid_ff;
  assign rspRdata = rdata_ff;
  assign rspRow = row_ff;
  assign busy = !isIdle;
  // Rule 7 path unused: host always issues chip-enable writes
  // Reads never turn into writes mid-cycle, so no bus turnaround
endmodule

// File: bench/fbac_mem_model.sv
// Behavioural bytewide memory facing the host controller.
// Assumes the bench resolves the shared data bus with a small delay.
`timescale 1ns/1ps
module fbac_mem_model (
  input wire logic chipEnN, // Chip enable, low
  input wire logic writeEnN, // Write enable, low
  input wire logic outEnN, // Output enable, low
  input wire logic [14:0] addr_lines, // Address pins
  input wire logic [7:0] busIn, // Resolved bus level
  output logic [7:0] memDq, // Read drive value
  output logic memOe // High while model drives
);
  logic [7:0] mem [0:32767];
  logic [14:0] lat;
  logic wrCyc = 0;
  logic ready = 0;
  always @(negedge chipEnN) begin
    lat = addr_lines;
    wrCyc = !writeEnN;
    ready = 0;
    #70 ready = 1;
  end
  always @(negedge writeEnN) if (!chipEnN) wrCyc = 1;
  always @(posedge chipEnN or posedge writeEnN) begin
    if (wrCyc && ready) mem[lat] = busIn;
    wrCyc = 0;
  end
  assign memDq = mem[lat];
  assign memOe = !chipEnN && ready && !wrCyc && writeEnN && !outEnN;
endmodule

// File: bench/fbac_host_ctrl_monitor.sv
// Port assertions for the host controller.
// Assumes it is bound onto every fbac_host_ctrl instance.
`timescale 1ns/1ps
module fbac_host_ctrl_monitor (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic reqValid, // Request
  input wire logic reqReady, // Taken
  input wire logic reqWrite, // Write
  input wire logic rspValid, // Done
  input wire logic [11:0] rspRow, // Row
  input wire logic busy, // Busy
  input wire logic chipEnN, // Chip enable
  input wire logic writeEnN, // Write enable
  input wire logic outEnN, // Output enable
  input wire logic [14:0] addr_lines, // Address
  input wire logic [7:0] data_lines_o, // Bus drive
  input wire logic data_lines_oe // Bus enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence take_s; reqValid && reqReady; endsequence
  sequence access_s; !chipEnN [*4] ##1 chipEnN; endsequence
  ce_fall_a: assert property (take_s |-> ##2 $fell(chipEnN))
    else $error("chip enable did not fall after take");
  ce_low_a: assert property ($fell(chipEnN) |-> access_s)
    else $error("chip enable low time wrong");
  precharge_a: assert property ($rose(chipEnN) |-> chipEnN [*4])
    else $error("precharge too short");
  rsp_time_a: assert property (take_s |-> ##6 rspValid)
    else $error("completion not on time");
  refuse_a: assert property (reqReady |-> !busy && chipEnN
    && $past(chipEnN, 4))
    else $error("request taken before precharge ended");
  wr_mode_a: assert property (take_s ##0 reqWrite |->
    ##1 (!writeEnN && data_lines_oe) ##1 $fell(chipEnN))
    else $error("write enable not ahead of chip enable");
  rd_oe_a: assert property (take_s ##0 !reqWrite |->
    ##2 (!outEnN && writeEnN && !data_lines_oe) [*4])
    else $error("read strobes wrong");
  wdata_a: assert property (!writeEnN && $past(!writeEnN) |->
    $stable(data_lines_o) && data_lines_oe)
    else $error("write data moved");
  wr_end_a: assert property ($rose(writeEnN) |-> $rose(chipEnN))
    else $error("write ended apart from chip enable");
  row_a: assert property (rspValid |-> rspRow == addr_lines[14:3])
    else $error("row does not match address");
endmodule
bind fbac_host_ctrl fbac_host_ctrl_monitor i_mon (.clk, .sys_rst,
  .reqValid, .reqReady, .reqWrite, .rspValid, .rspRow, .busy, .chipEnN,
  .writeEnN, .outEnN, .addr_lines, .data_lines_o, .data_lines_oe);

// File: bench/tb_fbac_host_ctrl.sv
// Self-checking bench: controller against the behavioural memory.
// Assumes the monitor binds itself onto the controller.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_fbac_host_ctrl;
  typedef struct packed {logic rd; logic [7:0] d; logic [11:0] row;} fbac_exp_s;
  logic clk = 0, sys_rst = 1, reqValid = 0, reqWrite = 0;
  logic reqReady, rspValid, busy, chipEnN, writeEnN, outEnN, oe, memOe;
  logic [14:0] reqAddr = '0, addr_lines, adr [8];
  logic [7:0] reqWdata = '0, rspRdata, dqo, memDq, dqBus, idlePat = 8'ha5;
  logic [11:0] rspRow;
  logic [7:0] shadow [int];
  fbac_exp_s expQ [$], e;
  int n_errors = 0, n_tests = 0, cyc = 0, seed = 33494;
  always #10 clk = ~clk;
  always @(posedge clk) idlePat <= idlePat + 8'h3b;
  // Undriven bus shows a changing pattern
  assign #1 dqBus = oe ? dqo : memOe ? memDq : idlePat;
  fbac_host_ctrl i_dut (.clk, .sys_rst, .reqValid, .reqReady, .reqWrite,
    .reqAddr, .reqWdata, .rspValid, .rspRdata, .rspRow, .busy, .chipEnN,
    .writeEnN, .outEnN, .addr_lines, .data_lines_i(dqBus),
    .data_lines_o(dqo), .data_lines_oe(oe));
  fbac_mem_model i_mem (.chipEnN, .writeEnN, .outEnN, .addr_lines,
    .busIn(dqBus), .memDq, .memOe);
  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d);
    @(negedge clk);
    reqValid = 1; reqWrite = w; reqAddr = a; reqWdata = d;
    @(posedge clk);
    while (reqReady !== 1'b1) @(posedge clk);
    if (w) shadow[a] = d;
    expQ.push_back({!w, w ? 8'h00 : shadow[a], a[14:3]});
    @(negedge clk);
    reqValid = 0;
  endtask
  always @(negedge clk) begin
    if (!sys_rst && rspValid === 1'b1) begin
      if (expQ.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = expQ.pop_front();
        `CHK(rspRow, e.row)
        if (e.rd) `CHK(rspRdata, e.d)
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin n_errors++; close_out(); end
  end
  initial begin
    adr = '{15'h0000, 15'h0007, 15'h0008, 15'h7fff, 0, 0, 0, 0};
    for (int i = 4; i < 8; i++) adr[i] = 15'($random(seed));
    repeat (6) @(negedge clk);
    sys_rst = 0;
    `CHK(chipEnN, 1'b1)
    for (int i = 0; i < 8; i++) op(1, adr[i], 8'($random(seed)));
    $display("test write done");
    for (int i = 0; i < 8; i++) op(0, adr[i], 8'h00);
    $display("test readback done");
    for (int i = 1; i < 3; i++) begin
      op(1, adr[i], ~shadow[adr[i]]);
      op(0, adr[i], 8'h00);
    end
    op(0, adr[2] - 15'h0001, 8'h00);
    repeat (12) @(negedge clk);
    `CHK(expQ.size(), 0)
    `CHK(oe, 1'b0)
    $display("test overwrite done");
    close_out();
  end
endmodule
